// *** testbench/flash_ecc_test_signature_tb_top.sv ***
// Self-checking testbench for the flash ECC test-input and signature register block
`default_nettype none

module flash_ecc_test_signature_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals and model state
  localparam int NR = 4;
  logic                  clk;
  logic                  rst_n = 1'b0, modify_done = 1'b1, rd_valid = 1'b0;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]           wdata = 32'h00000000;
  logic [3:0]            wstrb = 4'hf;
  logic [143:0]          rd_data = 144'h0;
  logic                  awready, wready, bvalid, arready, rvalid, rd_req, force_en, integ_done;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata, lfsr, test_lo, test_hi, word;
  logic [$clog2(NR)-1:0] rd_index;
  logic [63:0]           force_data;
  logic [7:0]            force_syn;
  logic [143:0]          sig;
  int                    errors, tests_run;
  int                    req_count, req_used;

  flash_ecc_test_signature #(.NUM_READS(NR)) u_flash_ecc_test_signature (
    .CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MODIFY_DONE(modify_done), .ARRAY_RD_REQ(rd_req),
    .READ_INDEX(rd_index), .ARRAY_RD_VALID(rd_valid), .ARRAY_RD_DATA(rd_data), .ECC_FORCE_EN(force_en),
    .ECC_FORCE_DATA(force_data), .ECC_FORCE_SYNDROME(force_syn), .INTEGRITY_DONE(integ_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Request pulses are counted so none is lost while a bus task runs
  always @(posedge clk) begin
    if (rd_req === 1'b1) begin
      req_count <= req_count + 1;
    end
  end

  // ==========================================================
  // Helpers: random source, signature model, comparisons
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic [143:0] misr(input logic [143:0] s, input logic [143:0] d);
    return {s[142:0], s[143]} ^ d ^ (flash_sig_pkg::MISR_TAPS & {144{s[143]}});
  endfunction : misr

  task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: bus word %h, expected %h", $time, got, exp);
    end
  endtask : compare_word

  task automatic compare_pin(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: port value %h, expected %h", $time, got, exp);
    end
  endtask : compare_pin

  // ==========================================================
  // Register bus master; values sampled at the negedge equal those seen at the next rising edge
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_r);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge clk);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    compare_word({30'h0, r}, {30'h0, exp_r});
  endtask : write_reg

  task automatic check_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
    logic ar_hs, r_hs;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge clk);
      ar_hs = arvalid & arready;
      r_hs = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    compare_word(d, exp);
    compare_word({30'h0, r}, {30'h0, exp_r});
  endtask : check_read

  task automatic check_slices();
    for (int s = 0; s < 4; s++) begin
      check_read(flash_sig_pkg::OFF_SIG0 + 8'(4 * s), sig[32*s +: 32], flash_sig_pkg::RESP_OKAY);
    end
  endtask : check_slices

  // ==========================================================
  // Array side: answers each read request, slower for later indices
  task automatic run_reads(input int n, input logic ecc, input logic probe);
    logic [143:0] d;
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (req_count <= req_used && k < 64);
      compare_pin(64'(req_count - req_used), 64'h1);
      req_used++;
      compare_pin(64'(rd_index), 64'(i));
      compare_pin(64'(force_en), 64'(ecc));
      compare_pin(64'(integ_done), 64'h0);
      if (probe && i == 0) begin
        check_read(flash_sig_pkg::OFF_SIG1, 32'h0, flash_sig_pkg::RESP_OKAY);
        write_reg(flash_sig_pkg::OFF_TEST_LOW, ~test_lo, flash_sig_pkg::RESP_OKAY);
      end
      d = 144'({rnd(), rnd(), rnd(), rnd(), rnd()});
      repeat (i) @(posedge clk);
      @(posedge clk);
      rd_valid <= 1'b1;
      rd_data <= d;
      @(posedge clk);
      rd_valid <= 1'b0;
      rd_data <= ~d;
      sig = misr(sig, d);
    end
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (integ_done !== 1'b1 && k < 8);
    compare_pin(64'(integ_done), 64'h1);
    compare_pin(64'(force_en), 64'h0);
  endtask : run_reads

  task automatic finish_test();
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    lfsr = 32'h00000013;
    sig = flash_sig_pkg::SIG_RESET;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    check_read(flash_sig_pkg::OFF_CTRL, flash_sig_pkg::CTRL_RESET, flash_sig_pkg::RESP_OKAY);
    check_read(8'h40, 32'h0, flash_sig_pkg::RESP_SLVERR);
    write_reg(8'h40, rnd(), flash_sig_pkg::RESP_SLVERR);
    modify_done <= 1'b0;
    write_reg(flash_sig_pkg::OFF_TEST_HIGH, rnd(), flash_sig_pkg::RESP_OKAY);
    write_reg(flash_sig_pkg::OFF_SIG3, rnd(), flash_sig_pkg::RESP_OKAY);
    check_read(flash_sig_pkg::OFF_TEST_HIGH, 32'h0, flash_sig_pkg::RESP_OKAY);
    modify_done <= 1'b1;
    check_read(flash_sig_pkg::OFF_TEST_HIGH, flash_sig_pkg::TEST_RESET, flash_sig_pkg::RESP_OKAY);
    check_slices();
    test_lo = rnd();
    test_hi = rnd();
    write_reg(flash_sig_pkg::OFF_TEST_LOW, test_lo, flash_sig_pkg::RESP_OKAY);
    write_reg(flash_sig_pkg::OFF_TEST_HIGH, test_hi, flash_sig_pkg::RESP_OKAY);
    check_read(flash_sig_pkg::OFF_TEST_LOW, test_lo, flash_sig_pkg::RESP_OKAY);
    compare_pin(force_data, {test_hi, test_lo});
    for (int s = 0; s < 4; s++) begin
      word = rnd();
      sig[32*s +: 32] = word;
      write_reg(flash_sig_pkg::OFF_SIG0 + 8'(4 * s), word, flash_sig_pkg::RESP_OKAY);
    end
    check_slices();
    // Integrity check over all reads, with bus probes while busy
    write_reg(flash_sig_pkg::OFF_CTRL, 32'h00000008, flash_sig_pkg::RESP_OKAY);
    run_reads(NR, 1'b0, 1'b1);
    check_slices();
    compare_pin(force_data, {test_hi, test_lo});
    write_reg(flash_sig_pkg::OFF_CTRL, 32'h00000000, flash_sig_pkg::RESP_OKAY);
    // ECC logic check: select first, then start
    word = rnd();
    word = {16'h0, word[15:8], 8'h10};
    write_reg(flash_sig_pkg::OFF_CTRL, word, flash_sig_pkg::RESP_OKAY);
    compare_pin(64'(force_en), 64'h0);
    write_reg(flash_sig_pkg::OFF_CTRL, word | 32'h00000008, flash_sig_pkg::RESP_OKAY);
    compare_pin(64'(force_syn), 64'(word[15:8]));
    run_reads(1, 1'b1, 1'b0);
    check_slices();
    write_reg(flash_sig_pkg::OFF_CTRL, 32'h00000000, flash_sig_pkg::RESP_OKAY);
    // Start refused with each of erase, program and high voltage
    for (int b = 0; b < 3; b++) begin
      write_reg(flash_sig_pkg::OFF_CTRL, (32'h1 << b) | 32'h00000008, flash_sig_pkg::RESP_OKAY);
      check_read(flash_sig_pkg::OFF_STATUS, 32'h00000003, flash_sig_pkg::RESP_OKAY);
      compare_pin(64'(integ_done), 64'h1);
      write_reg(flash_sig_pkg::OFF_CTRL, 32'h00000000, flash_sig_pkg::RESP_OKAY);
    end
    finish_test();
  end
endmodule : flash_ecc_test_signature_tb_top

`default_nettype wire

// *** verilog/flash_ecc_test_signature.sv ***
// Flash ECC test-input and array signature registers behind an AXI4-Lite slave
//
// Notes on behaviour
// RULE1 - Test-input registers read as zero and ignore writes unless both done flags are high.
// RULE2 - The low test-input word drives bits 31:0 of the forced ECC double word.
// RULE3 - Each test-input bit forces its ECC input to the value written.
// RULE4 - The high test-input word drives bits 63:32 of the forced ECC double word.
// RULE5 - Signature slice 0 shows signature bits 31:0.
// RULE6 - Signature slice 1 shows signature bits 63:32.
// RULE7 - Signature slice 2 shows signature bits 95:64.
// RULE8 - Signature slice 3 shows signature bits 127:96.
// RULE9 - Every array read during a check is folded into the signature.
// RULE10 - A software write to a slice seeds the signature from which accumulation continues.
// RULE11 - Signature slices read as zero and ignore writes unless both done flags are high.
// RULE12 - The integrity-done flag drops when a check starts and rises when it ends.
// RULE13 - The ECC check runs only while the ECC-check enable bit is set.
// RULE14 - During an ECC check the syndrome field forces the eight syndrome bits.
// RULE15 - The start bit can be set only while erase, program and high-voltage bits are low.
// RULE16 - The signature is a linear-feedback shift over the 144-bit state, one step per read.
`default_nettype none

module flash_ecc_test_signature #(
  parameter int NUM_READS = flash_sig_pkg::NUM_READS_DEFAULT
) (
  input  wire logic                              CLK,
  input  wire logic                              RST_N,
  input  wire logic [flash_sig_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
  input  wire logic                              S_AXI_AWVALID,
  output logic                                   S_AXI_AWREADY,
  input  wire logic [31:0]                       S_AXI_WDATA,
  input  wire logic [3:0]                        S_AXI_WSTRB,
  input  wire logic                              S_AXI_WVALID,
  output logic                                   S_AXI_WREADY,
  output logic [1:0]                             S_AXI_BRESP,
  output logic                                   S_AXI_BVALID,
  input  wire logic                              S_AXI_BREADY,
  input  wire logic [flash_sig_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
  input  wire logic                              S_AXI_ARVALID,
  output logic                                   S_AXI_ARREADY,
  output logic [31:0]                            S_AXI_RDATA,
  output logic [1:0]                             S_AXI_RRESP,
  output logic                                   S_AXI_RVALID,
  input  wire logic                              S_AXI_RREADY,
  input  wire logic                              MODIFY_DONE,
  output logic                                   ARRAY_RD_REQ,
  output logic [$clog2(NUM_READS)-1:0]           READ_INDEX,
  input  wire logic                              ARRAY_RD_VALID,
  input  wire logic [flash_sig_pkg::WORD_W-1:0]  ARRAY_RD_DATA,
  output logic                                   ECC_FORCE_EN,
  output logic [63:0]                            ECC_FORCE_DATA,
  output logic [flash_sig_pkg::SYN_W-1:0]        ECC_FORCE_SYNDROME,
  output logic                                   INTEGRITY_DONE
);

  localparam int IDX_W = $clog2(NUM_READS);

  logic [flash_sig_pkg::ADDR_W-1:0]  wr_addr;
  logic [31:0]                       wr_data;
  logic [3:0]                        wr_strb;
  logic [31:0]                       ctrl;
  logic [31:0]                       test_low;
  logic [31:0]                       test_high;
  logic [flash_sig_pkg::WORD_W-1:0]  sig_state;
  flash_sig_pkg::seq_state_t         seq;

  // ==========================================================
  // Write decode
  wire        access_ok  = MODIFY_DONE & INTEGRITY_DONE;
  wire        wr_go      = !S_AXI_AWREADY & !S_AXI_WREADY & !S_AXI_BVALID;
  wire [31:0] strb_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire        wr_ctrl    = wr_go & (wr_addr == flash_sig_pkg::OFF_CTRL);
  wire        wr_low     = wr_go & (wr_addr == flash_sig_pkg::OFF_TEST_LOW);
  wire        wr_high    = wr_go & (wr_addr == flash_sig_pkg::OFF_TEST_HIGH);
  wire        wr_sig_hit = (wr_addr >= flash_sig_pkg::OFF_SIG0) & (wr_addr <= flash_sig_pkg::OFF_SIG3)
                         & (wr_addr[1:0] == 2'h0);
  wire        wr_mapped  = wr_sig_hit | (wr_addr[1:0] == 2'h0) & (wr_addr <= flash_sig_pkg::OFF_TEST_HIGH);
  wire [1:0]  wr_slice   = wr_addr[3:2];

  // ==========================================================
  // Control register next value
  wire [31:0] ctrl_merged = ((ctrl & ~strb_mask) | (wr_data & strb_mask)) & flash_sig_pkg::CTRL_MASK;
  // RULE15 - start refused while erase, program or high voltage is selected
  wire        start_allowed = !ctrl_merged[flash_sig_pkg::CTRL_ERASE] & !ctrl_merged[flash_sig_pkg::CTRL_PROGRAM]
                            & !ctrl_merged[flash_sig_pkg::CTRL_HV];
  wire        keep_start = ctrl_merged[flash_sig_pkg::CTRL_START] & (ctrl[flash_sig_pkg::CTRL_START] | start_allowed);
  wire [31:0] ctrl_open  = keep_start ? (ctrl_merged | flash_sig_pkg::CTRL_START_MASK)
                                      : (ctrl_merged & ~flash_sig_pkg::CTRL_START_MASK);
  // While an operation runs only clearing the start bit gets through
  wire [31:0] ctrl_lock  = ctrl_merged[flash_sig_pkg::CTRL_START] ? ctrl
                                                                  : (ctrl & ~flash_sig_pkg::CTRL_START_MASK);
  wire [31:0] next_ctrl  = !wr_ctrl ? ctrl : (access_ok ? ctrl_open : ctrl_lock);
  wire        launch     = wr_ctrl & access_ok & keep_start & !ctrl[flash_sig_pkg::CTRL_START];

  // ==========================================================
  // Read decode
  wire [flash_sig_pkg::ADDR_W-1:0] ra = S_AXI_ARADDR;
  wire        rd_sig_hit = (ra >= flash_sig_pkg::OFF_SIG0) & (ra <= flash_sig_pkg::OFF_SIG3) & (ra[1:0] == 2'h0);
  wire        rd_test    = (ra == flash_sig_pkg::OFF_TEST_LOW) | (ra == flash_sig_pkg::OFF_TEST_HIGH);
  wire        rd_mapped  = rd_sig_hit | (ra[1:0] == 2'h0) & (ra <= flash_sig_pkg::OFF_TEST_HIGH);
  wire [31:0] status_word = {29'h0, seq != flash_sig_pkg::SEQ_IDLE, INTEGRITY_DONE, MODIFY_DONE};
  // RULE5 RULE6 RULE7 RULE8 slice k maps to signature bits 32k+31:32k
  wire [31:0] rd_sig     = sig_state[32*ra[3:2] +: 32];
  wire [31:0] rd_raw     = rd_sig_hit                            ? rd_sig :
                           (ra == flash_sig_pkg::OFF_CTRL)       ? ctrl :
                           (ra == flash_sig_pkg::OFF_STATUS)     ? status_word :
                           (ra == flash_sig_pkg::OFF_TEST_LOW)   ? test_low :
                           (ra == flash_sig_pkg::OFF_TEST_HIGH)  ? test_high : 32'h0;
  // RULE1 RULE11 gated reads return zero
  wire [31:0] rd_value   = ((rd_sig_hit | rd_test) & !access_ok) ? 32'h0 : rd_raw;

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= flash_sig_pkg::RESP_OKAY;
      wr_addr       <= '0;
      wr_data       <= 32'h0;
      wr_strb       <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        wr_addr       <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        wr_data      <= S_AXI_WDATA;
        wr_strb      <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_mapped ? flash_sig_pkg::RESP_OKAY : flash_sig_pkg::RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= flash_sig_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_value;
      S_AXI_RRESP   <= rd_mapped ? flash_sig_pkg::RESP_OKAY : flash_sig_pkg::RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl      <= flash_sig_pkg::CTRL_RESET;
      test_low  <= flash_sig_pkg::TEST_RESET;
      test_high <= flash_sig_pkg::TEST_RESET;
    end else begin
      ctrl <= next_ctrl;
      // RULE1 RULE3 test words store each written bit when open
      if (wr_low && access_ok) begin
        test_low <= (test_low & ~strb_mask) | (wr_data & strb_mask);
      end
      if (wr_high && access_ok) begin
        test_high <= (test_high & ~strb_mask) | (wr_data & strb_mask);
      end
    end
  end

  // RULE2 RULE4 forced double word, even word low
  assign ECC_FORCE_DATA     = {test_high, test_low};
  // RULE14 syndrome field forced beside the data
  assign ECC_FORCE_SYNDROME = ctrl[flash_sig_pkg::CTRL_SYN_LSB +: flash_sig_pkg::SYN_W];

  // ==========================================================
  // Check sequencer
  wire rd_taken  = (seq == flash_sig_pkg::SEQ_WAIT) & ARRAY_RD_VALID;
  // An ECC check needs one read of the forced word only
  wire last_read = ECC_FORCE_EN | (READ_INDEX == IDX_W'(NUM_READS - 1));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      seq            <= flash_sig_pkg::SEQ_IDLE;
      INTEGRITY_DONE <= 1'b1;
      ECC_FORCE_EN   <= 1'b0;
      ARRAY_RD_REQ   <= 1'b0;
      READ_INDEX     <= '0;
    end else begin
      ARRAY_RD_REQ <= 1'b0;
      case (seq)
        flash_sig_pkg::SEQ_IDLE: begin
          // RULE12 done drops as the check starts
          if (launch) begin
            seq            <= flash_sig_pkg::SEQ_WAIT;
            INTEGRITY_DONE <= 1'b0;
            // RULE13 ECC check only with enable set
            ECC_FORCE_EN   <= ctrl_open[flash_sig_pkg::CTRL_ECC_EN];
            ARRAY_RD_REQ   <= 1'b1;
            READ_INDEX     <= '0;
          end
        end
        flash_sig_pkg::SEQ_WAIT: begin
          // RULE9 each returned read advances the walk
          if (rd_taken && last_read) begin
            seq <= flash_sig_pkg::SEQ_FINISH;
          end else if (rd_taken) begin
            ARRAY_RD_REQ <= 1'b1;
            READ_INDEX   <= READ_INDEX + IDX_W'(1);
          end
        end
        flash_sig_pkg::SEQ_FINISH: begin
          // RULE12 done rises when the check ends
          seq            <= flash_sig_pkg::SEQ_IDLE;
          INTEGRITY_DONE <= 1'b1;
          ECC_FORCE_EN   <= 1'b0;
        end
        default: begin
          seq <= flash_sig_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Signature accumulator
  // RULE10 RULE11 seed writes only while open
  wire [3:0]  sig_load  = (wr_go & wr_sig_hit & access_ok) ? (4'h1 << wr_slice) : 4'h0;
  wire [31:0] sig_old   = sig_state[32*wr_slice +: 32];
  wire [31:0] sig_seed  = (sig_old & ~strb_mask) | (wr_data & strb_mask);

  signature_shift_reg #(
    .WIDTH   (flash_sig_pkg::WORD_W),
    .SLICE_W (flash_sig_pkg::DATA_W),
    .SLICES  (flash_sig_pkg::SIG_SLICES)
  ) u_signature (
    .clk       (CLK),
    .rst_n     (RST_N),
    .step      (rd_taken),
    .data_in   (ARRAY_RD_DATA),
    .load_sel  (sig_load),
    .load_data (sig_seed),
    .state     (sig_state)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  wire ar_go = S_AXI_ARVALID & S_AXI_ARREADY;

  a_test_write_lock : assert property (wr_low && !access_ok |=> $stable(test_low)) // RULE1
    else $error("test word changed while locked");
  a_low_word_force : assert property (wr_low && access_ok && wr_strb == 4'hf |=> // RULE2
    ECC_FORCE_DATA[31:0] == $past(wr_data))
    else $error("low forced word differs from written value");
  a_force_bits_hold : assert property (ECC_FORCE_EN && !wr_go |=> $stable(ECC_FORCE_DATA)) // RULE3
    else $error("forced bits moved during ECC check");
  a_high_word_force : assert property (wr_high && access_ok && wr_strb == 4'hf |=> // RULE4
    ECC_FORCE_DATA[63:32] == $past(wr_data))
    else $error("high forced word differs from written value");
  a_slice0_read : assert property (ar_go && access_ok && ra == flash_sig_pkg::OFF_SIG0 |=> // RULE5
    S_AXI_RDATA == $past(sig_state[31:0]))
    else $error("slice 0 read wrong bits");
  a_slice1_read : assert property (ar_go && access_ok && ra == flash_sig_pkg::OFF_SIG1 |=> // RULE6
    S_AXI_RDATA == $past(sig_state[63:32]))
    else $error("slice 1 read wrong bits");
  a_slice2_read : assert property (ar_go && access_ok && ra == flash_sig_pkg::OFF_SIG2 |=> // RULE7
    S_AXI_RDATA == $past(sig_state[95:64]))
    else $error("slice 2 read wrong bits");
  a_slice3_read : assert property (ar_go && access_ok && ra == flash_sig_pkg::OFF_SIG3 |=> // RULE8
    S_AXI_RDATA == $past(sig_state[127:96]))
    else $error("slice 3 read wrong bits");
  a_read_walk_next : assert property (rd_taken && !last_read |=> ARRAY_RD_REQ ##1 !ARRAY_RD_REQ) // RULE9
    else $error("next array read not requested");
  a_seed_write : assert property (wr_go && wr_sig_hit && access_ok && wr_strb == 4'hf |=> // RULE10
    sig_state[32*$past(wr_slice) +: 32] == $past(wr_data))
    else $error("signature seed not stored");
  a_gated_read_zero : assert property (ar_go && rd_sig_hit && !access_ok |=> S_AXI_RDATA == 32'h0) // RULE11
    else $error("locked signature read returned data");
  a_done_cycle : assert property (launch |=> !INTEGRITY_DONE ##[1:1000] INTEGRITY_DONE) // RULE12
    else $error("done flag did not drop on start or rise at the end");
  a_ecc_needs_enable : assert property ($rose(ECC_FORCE_EN) |-> // RULE13
    $past(ctrl_open[flash_sig_pkg::CTRL_ECC_EN]) && !INTEGRITY_DONE)
    else $error("ECC check ran without enable");
  a_syndrome_drive : assert property (ECC_FORCE_EN |=> $stable(ECC_FORCE_SYNDROME)) // RULE14
    else $error("forced syndrome moved during ECC check");
  a_start_lockout : assert property (wr_ctrl && access_ok && !start_allowed // RULE15
    && !ctrl[flash_sig_pkg::CTRL_START] |=> !ctrl[flash_sig_pkg::CTRL_START] && seq == flash_sig_pkg::SEQ_IDLE)
    else $error("start accepted with erase, program or high voltage set");

  c_integrity_run : cover property (launch && !ctrl_open[flash_sig_pkg::CTRL_ECC_EN] ##[1:200] INTEGRITY_DONE);
  c_ecc_run       : cover property (ECC_FORCE_EN ##[1:20] INTEGRITY_DONE);
  c_locked_write  : cover property (wr_go && wr_sig_hit && !access_ok);
  c_start_refused : cover property (wr_ctrl && !start_allowed && ctrl_merged[flash_sig_pkg::CTRL_START]);

endmodule : flash_ecc_test_signature

`default_nettype wire

// *** verilog/flash_sig_pkg.sv ***
// Offsets, fields, reset values and types shared by the flash signature block
`default_nettype none

package flash_sig_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int WORD_W     = 144;
  localparam int SIG_SLICES = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_TEST_LOW  = 8'h08;
  localparam logic [7:0] OFF_TEST_HIGH = 8'h0c;
  localparam logic [7:0] OFF_SIG0      = 8'h10;
  localparam logic [7:0] OFF_SIG1      = 8'h14;
  localparam logic [7:0] OFF_SIG2      = 8'h18;
  localparam logic [7:0] OFF_SIG3      = 8'h1c;

  // ==========================================================
  // Control and status fields
  localparam int CTRL_ERASE    = 0;
  localparam int CTRL_PROGRAM  = 1;
  localparam int CTRL_HV       = 2;
  localparam int CTRL_START    = 3;
  localparam int CTRL_ECC_EN   = 4;
  localparam int CTRL_SYN_LSB  = 8;
  localparam int SYN_W         = 8;
  localparam int STAT_MODIFY   = 0;
  localparam int STAT_INTEG    = 1;
  localparam int STAT_BUSY     = 2;
  localparam logic [31:0] CTRL_MASK       = 32'h0000ff1f;
  localparam logic [31:0] CTRL_START_MASK = 32'h00000008;

  // ==========================================================
  // Reset values and signature feedback
  localparam logic [31:0]  CTRL_RESET = 32'h00000000;
  localparam logic [31:0]  TEST_RESET = 32'h00000000;
  localparam logic [143:0] SIG_RESET  = 144'h0;
  localparam logic [143:0] MISR_TAPS  = 144'h0000_0000_0000_0000_0000_0000_0000_0000_0086;
  localparam int NUM_READS_DEFAULT    = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'h0,
    SEQ_WAIT   = 2'h1,
    SEQ_FINISH = 2'h3
  } seq_state_t;

endpackage : flash_sig_pkg

`default_nettype wire

// *** verilog/signature_shift_reg.sv ***
// Multiple-input signature shift register with per-slice software seeding
`default_nettype none

module signature_shift_reg #(
  parameter int WIDTH   = flash_sig_pkg::WORD_W,
  parameter int SLICE_W = flash_sig_pkg::DATA_W,
  parameter int SLICES  = flash_sig_pkg::SIG_SLICES
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               step,
  input  wire logic [WIDTH-1:0]   data_in,
  input  wire logic [SLICES-1:0]  load_sel,
  input  wire logic [SLICE_W-1:0] load_data,
  output logic      [WIDTH-1:0]   state
);

  wire              fb = state[WIDTH-1];
  logic [WIDTH-1:0] next_shift;
  logic [WIDTH-1:0] next_load;

  // ==========================================================
  // Shift and seed paths
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      if (i == 0) begin : g_first
        assign next_shift[i] = fb ^ data_in[i];
      end else begin : g_rest
        assign next_shift[i] = state[i-1] ^ data_in[i] ^ (flash_sig_pkg::MISR_TAPS[i] & fb);
      end
      if (i < SLICES * SLICE_W) begin : g_seed
        assign next_load[i] = load_sel[i / SLICE_W] ? load_data[i % SLICE_W] : state[i];
      end else begin : g_keep
        assign next_load[i] = state[i];
      end
    end
  endgenerate

  // RULE16 - one shift per read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= WIDTH'(flash_sig_pkg::SIG_RESET);
    end else begin
      state <= step ? next_shift : next_load;
    end
  end

  // RULE16 - feedback into bit zero
  a_shift_bit0 : assert property (@(posedge clk) disable iff (!rst_n)
    step |=> state[0] == ($past(state[WIDTH-1]) ^ $past(data_in[0])))
    else $error("signature bit zero did not take the feedback");

endmodule : signature_shift_reg

`default_nettype wire
